// ==== include/input_scaling_pkg.sv ====
package input_scaling_pkg;

	// ==========================================================
	// Register map, byte addresses on the 32-bit slave.
	localparam logic [5:0] OFS_CTRL      = 6'h00;
	localparam logic [5:0] OFS_OFFSET    = 6'h04;
	localparam logic [5:0] OFS_DISP_LO   = 6'h08;
	localparam logic [5:0] OFS_DISP_HI   = 6'h0C;
	localparam logic [5:0] OFS_RANGE_EXP = 6'h10;
	localparam logic [5:0] OFS_PT_STAGE  = 6'h14;
	localparam logic [5:0] OFS_COMMAND   = 6'h18;
	localparam logic [5:0] OFS_STATUS    = 6'h1C;
	localparam logic [5:0] OFS_RESULT    = 6'h20;

	// ==========================================================
	// Field positions and reset values.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CHAR_LSB = 4;
	localparam int CTRL_WIRE_LSB = 8;
	localparam int CTRL_DEC_LSB  = 12;
	localparam int RX_LO_LSB     = 0;
	localparam int RX_HI_LSB     = 16;
	localparam int PT_X_LSB      = 0;
	localparam int PT_Y_LSB      = 16;
	localparam logic [15:0] RST_DISP_LO = 16'h0000;
	localparam logic [15:0] RST_DISP_HI = 16'h03E8;

	// ==========================================================
	// Limits, in points, display units, 0.1 % steps or 0.1 C steps.
	localparam int MAX_POINTS   = 20;
	localparam int MIN_POINTS   = 2;
	localparam int DISP_MIN     = -999;
	localparam int DISP_MAX     = 9999;
	localparam int X_MIN        = -999;
	localparam int X_MAX        = 1999;
	localparam int LOR_MAX      = 999;
	localparam int HIR_MAX      = 199;
	localparam int OFS_RTD_MAX  = 99;
	localparam int OFS_TC_MAX   = 990;
	localparam int PERMILLE     = 1000;

	// ==========================================================
	// Timing.
	localparam int CLK_MHZ       = 200;
	localparam int COUNT_SHOW_MS = 1500;
	localparam int LONG_PRESS_MS = 2000;
	localparam int COUNT_SHOW_CYC = COUNT_SHOW_MS * 1000 * CLK_MHZ;
	localparam int LONG_PRESS_CYC = LONG_PRESS_MS * 1000 * CLK_MHZ;

	typedef enum logic [3:0] {
		MODE_0_20 = 4'h0, MODE_4_20 = 4'h1, MODE_0_5 = 4'h2, MODE_1_5 = 4'h3,
		MODE_0_10 = 4'h4, MODE_2_10 = 4'h5, MODE_RTD = 4'h6, MODE_TC  = 4'h7
	} input_mode_t;

	typedef enum logic [1:0] {
		CHAR_LIN = 2'h0, CHAR_SQR = 2'h1, CHAR_SQRT = 2'h2, CHAR_USER = 2'h3
	} char_t;

	typedef enum logic [1:0] {
		WIRE_4 = 2'h0, WIRE_3 = 2'h1, WIRE_2 = 2'h2
	} wiring_t;

	typedef enum logic [2:0] {
		CMD_EXIT = 3'h0, CMD_APPEND = 3'h1, CMD_REMOVE = 3'h2, CMD_MODIFY = 3'h3,
		CMD_COMMIT = 3'h4
	} command_t;

	typedef enum logic [3:0] {
		SHOW_VALUE = 4'h0, SHOW_UNDER = 4'h1, SHOW_OVER = 4'h2, SHOW_OVFL = 4'h3,
		SHOW_FEWPT = 4'h4, SHOW_DUP = 4'h5, SHOW_PROMPT = 4'h6, SHOW_COUNT = 4'h7
	} show_t;

	typedef struct packed {
		show_t              code;
		logic signed [15:0] value;
		logic [1:0]         decimals;
		logic               xmark;
	} display_t;

endpackage

// ==== rtl/input_scaling_range_check.sv ====
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - Three RTD wiring choices, four, three or two wire, drive the front end.
// - Signed offset added to temperature, limited to 9.9 C RTD or 99 C TC.
// - Offset acts after, and apart from, cold-junction compensation.
// - Linear, square, square-root or point-table characteristic for current and voltage.
// - Point table holds at most twenty points; more are refused.
// - Point table selected with under two points shows the few-points warning.
// - Zero to three decimals, stepped with up and down keys.
// - Low and high display values map min and max input, range -999 to 9999.
// - With point table, low and high display values are read-only and derived.
// - New point takes X from -99.9 to 199.9 percent and Y from -999 to 9999.
// - Point with an existing X is refused and the duplicate warning shown.
// - While X is shown an extra rightmost decimal point lights.
// - Remove shows count 1.5 s, keys pick point, short enter toggles X and Y.
// - Enter held 2 s raises confirm prompt; next enter removes and shows count.
// - In modify, enter held 2 s opens the coordinate; short press toggles.
// - Point functions exist only while the point table is selected.
// - Input inside permissible range shows result, below under, above over warning.
// - Lower expansion only for live-zero modes, otherwise lower border is zero.
// - Lower border is nominal low minus low times lower percentage, 0 to 99.9.
// - Upper border is nominal high plus high times upper percentage, 0 to 19.9.
// - In-range input whose display leaves -999 to 9999 shows overflow warning.
// - Modes 0-20, 4-20 mA and 0-5, 1-5, 0-10, 2-10 V set nominal limits.
module input_scaling_range_check
	import input_scaling_pkg::*;
#(
	parameter int unsigned COUNT_SHOW = COUNT_SHOW_CYC, // count display time, cycles
	parameter int unsigned LONG_PRESS = LONG_PRESS_CYC  // long enter press, cycles
)(
	input  wire logic               clk_i,             // 200 MHz clock
	input  wire logic               rstn_i,            // async reset, active low
	input  wire logic [5:0]         avs_address_i,     // byte address
	input  wire logic               avs_read_i,        // read request
	input  wire logic               avs_write_i,       // write request
	input  wire logic [31:0]        avs_writedata_i,   // write data
	input  wire logic [3:0]         avs_byteenable_i,  // byte lanes
	output logic      [31:0]        avs_readdata_o,    // read data
	output logic                    avs_waitrequest_o, // stall
	input  wire logic               sample_valid_i,    // new converted sample
	input  wire logic signed [23:0] sample_i,          // uA, mV or 0.1 C
	input  wire logic [2:0]         keys_i,            // up, down, enter pins
	output wiring_t                 rtd_wiring_o,      // wiring to front end
	output display_t                disp_o             // display word
);

	// ==========================================================
	// Registers.
	input_mode_t        mode_reg;
	char_t              char_reg;
	wiring_t            wire_reg;
	logic [1:0]         dec_reg;
	logic signed [15:0] offset_reg;
	logic signed [15:0] dlo_reg;
	logic signed [15:0] dhi_reg;
	logic [9:0]         lor_reg;
	logic [9:0]         hir_reg;
	logic signed [15:0] stage_x_reg;
	logic signed [15:0] stage_y_reg;
	logic signed [15:0] px_reg [MAX_POINTS];
	logic signed [15:0] py_reg [MAX_POINTS];
	logic [4:0]         count_reg;
	logic [4:0]         sel_reg;
	logic               dup_reg;
	logic               show_y_reg;
	logic               long_done_reg;
	logic               remove_op_reg;
	logic [31:0]        timer_reg;
	logic               ack_reg;
	logic [31:0]        rdata_reg;
	display_t           meas_reg;
	display_t           disp_reg;
	logic [2:0]         k1_reg;
	logic [2:0]         k2_reg;
	logic [2:0]         k3_reg;
	logic [2:0]         key_reg;
	logic [2:0]         key_prev_reg;

	typedef enum logic [4:0] {
		UI_IDLE = 5'b00001, UI_COUNT = 5'b00010, UI_SELECT = 5'b00100,
		UI_CONFIRM = 5'b01000, UI_EDIT = 5'b10000
	} ui_t;
	ui_t ui_reg;
	ui_t ui_next;

	// ==========================================================
	// Helpers.
	function automatic int clampi(input int v, input int lo, input int hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic int nom_lo(input input_mode_t m);
		case (m)
			MODE_4_20: return 4000;
			MODE_1_5:  return 1000;
			MODE_2_10: return 2000;
			default:   return 0;
		endcase
	endfunction

	function automatic int nom_hi(input input_mode_t m);
		case (m)
			MODE_0_5, MODE_1_5:   return 5000;
			MODE_0_10, MODE_2_10: return 10000;
			default:              return 20000;
		endcase
	endfunction

	function automatic int isqrt(input int v);
		int r;
		r = 0;
		for (int b = 15; b >= 0; b--)
			if ((r + (1 << b)) * (r + (1 << b)) <= v)
				r = r + (1 << b);
		return r;
	endfunction

	// Unsorted table: nearest points below and above are searched every time.
	function automatic int interp(input int p);
		int lx;
		int ly;
		int hx;
		int hy;
		logic lf;
		logic hf;
		lx = 0; ly = 0; hx = 0; hy = 0; lf = 1'b0; hf = 1'b0;
		for (int i = 0; i < MAX_POINTS; i++)
			if (i < int'(count_reg))
			begin
				if (px_reg[i] <= p && (!lf || px_reg[i] > lx))
				begin
					lf = 1'b1; lx = px_reg[i]; ly = py_reg[i];
				end
				if (px_reg[i] > p && (!hf || px_reg[i] < hx))
				begin
					hf = 1'b1; hx = px_reg[i]; hy = py_reg[i];
				end
			end
		if (lf && hf)
			return ly + (hy - ly) * (p - lx) / (hx - lx);
		return lf ? ly : hy;
	endfunction

	// ==========================================================
	// Measurement path.
	wire logic   live_zero = (mode_reg == MODE_4_20) || (mode_reg == MODE_1_5)
		|| (mode_reg == MODE_2_10);
	wire logic   is_temp   = (mode_reg == MODE_RTD) || (mode_reg == MODE_TC);
	wire logic   is_user   = (char_reg == CHAR_USER);
	wire integer lo_nom    = nom_lo(mode_reg);
	wire integer hi_nom    = nom_hi(mode_reg);
	wire integer lo_bord   = live_zero ? lo_nom - lo_nom * int'(lor_reg) / PERMILLE
		: 0;
	wire integer hi_bord   = hi_nom + hi_nom * int'(hir_reg) / PERMILLE;
	wire integer samp      = int'(sample_i);
	wire integer pct       = (samp - lo_nom) * PERMILLE / (hi_nom - lo_nom);
	wire integer shape     = (char_reg == CHAR_SQR) ? pct * pct / PERMILLE
		: (char_reg == CHAR_SQRT) ? ((pct > 0) ? isqrt(pct * PERMILLE) : 0) : pct;

	// The table lookups live in a process so that a changed point re-runs them.
	// A continuous assignment would only follow the lookup's own argument.
	int          user_lo;
	int          user_hi;
	int          user_pt;
	always_comb
	begin
		user_lo = interp(0);
		user_hi = interp(PERMILLE);
		user_pt = interp(pct);
	end

	wire integer scaled    = is_user ? user_pt
		: int'(dlo_reg) + (int'(dhi_reg) - int'(dlo_reg)) * shape / PERMILLE;
	wire integer ofs_lim   = (mode_reg == MODE_RTD) ? OFS_RTD_MAX : OFS_TC_MAX;
	wire integer temp_out  = samp + clampi(int'(offset_reg), -ofs_lim, ofs_lim);
	wire integer result    = is_temp ? temp_out : scaled;
	wire logic   below     = !is_temp && samp < lo_bord;
	wire logic   above     = !is_temp && samp > hi_bord;
	wire logic   ovfl      = result < DISP_MIN || result > DISP_MAX;
	wire logic   few_pts   = !is_temp && is_user && count_reg < 5'(MIN_POINTS);

	show_t meas_code;
	assign meas_code = few_pts ? SHOW_FEWPT : below ? SHOW_UNDER
		: above ? SHOW_OVER : ovfl ? SHOW_OVFL : SHOW_VALUE;

	// ==========================================================
	// Key synchroniser: a change counts once stages two and three agree.
	wire logic [2:0] key_rise = key_reg & ~key_prev_reg;
	wire logic       up_ev    = key_rise[2];
	wire logic       down_ev  = key_rise[1];
	wire logic       enter    = key_reg[0];
	wire logic       ent_rise = key_rise[0];
	wire logic       ent_fall = !key_reg[0] && key_prev_reg[0];
	wire logic       long_hit = enter && !long_done_reg && timer_reg == LONG_PRESS - 1;

	// ==========================================================
	// Register slave decode.
	wire logic       req     = (avs_read_i || avs_write_i) && !ack_reg;
	wire logic       wr      = avs_write_i && !ack_reg;
	wire logic       wr_full = wr && avs_byteenable_i == 4'hF;
	wire logic       cmd_wr  = wr_full && avs_address_i == OFS_COMMAND;
	wire command_t   cmd     = command_t'(avs_writedata_i[2:0]);
	wire logic       pt_cmd  = cmd_wr && is_user;
	wire logic [15:0] wd_lo  = avs_writedata_i[15:0];
	wire logic [15:0] wd_hi  = avs_writedata_i[31:16];
	wire logic       app_req = pt_cmd && cmd == CMD_APPEND && ui_reg == UI_IDLE;
	wire logic       cmt_req = pt_cmd && cmd == CMD_COMMIT && ui_reg == UI_EDIT;

	logic x_dup;
	always_comb
	begin
		x_dup = 1'b0;
		for (int i = 0; i < MAX_POINTS; i++)
			if (i < int'(count_reg) && px_reg[i] == stage_x_reg
				&& !(cmt_req && 5'(i) == sel_reg))
				x_dup = 1'b1;
	end

	wire logic app_ok  = app_req && !x_dup && count_reg < 5'(MAX_POINTS);
	wire logic edit_ok = cmt_req && (show_y_reg || !x_dup);
	wire logic del_now = ui_reg == UI_CONFIRM && ent_rise;

	logic [31:0] rd_mux;
	always_comb
	begin
		case (avs_address_i)
			OFS_CTRL:      rd_mux = {18'h0, dec_reg, 2'h0, wire_reg, 2'h0, char_reg, mode_reg};
			OFS_OFFSET:    rd_mux = {{16{offset_reg[15]}}, offset_reg};
			OFS_DISP_LO:   rd_mux = is_user ? 32'(user_lo) : {{16{dlo_reg[15]}}, dlo_reg};
			OFS_DISP_HI:   rd_mux = is_user ? 32'(user_hi) : {{16{dhi_reg[15]}}, dhi_reg};
			OFS_RANGE_EXP: rd_mux = {6'h0, hir_reg, 6'h0, lor_reg};
			OFS_PT_STAGE:  rd_mux = {stage_y_reg, stage_x_reg};
			OFS_STATUS:    rd_mux = {11'h0, ui_reg, 3'h0, sel_reg, 2'h0, dup_reg, count_reg};
			OFS_RESULT:    rd_mux = {12'h0, disp_reg.code, disp_reg.value};
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		ui_next = ui_reg;
		case (ui_reg)
			UI_IDLE:    if (pt_cmd && (cmd == CMD_REMOVE || cmd == CMD_MODIFY))
						ui_next = UI_COUNT;
			UI_COUNT:   if (timer_reg == COUNT_SHOW - 1)
						ui_next = UI_SELECT;
			UI_SELECT:  if (long_hit)
						ui_next = remove_op_reg ? UI_CONFIRM : UI_EDIT;
			UI_CONFIRM: if (del_now)
						ui_next = UI_COUNT;
			UI_EDIT:    if (cmt_req)
						ui_next = UI_SELECT;
			default:    ui_next = UI_IDLE;
		endcase
		if ((cmd_wr && cmd == CMD_EXIT) || !is_user)
			ui_next = UI_IDLE;
	end

	display_t disp_next;
	always_comb
	begin
		disp_next = meas_reg;
		disp_next.decimals = dec_reg;
		disp_next.xmark = 1'b0;
		case (ui_reg)
			UI_IDLE:    if (dup_reg)
					disp_next.code = SHOW_DUP;
			UI_COUNT:
			begin
				disp_next.code  = SHOW_COUNT;
				disp_next.value = 16'(count_reg);
			end
			UI_CONFIRM: disp_next.code = SHOW_PROMPT;
			default:
			begin
				disp_next.code  = dup_reg ? SHOW_DUP : SHOW_VALUE;
				disp_next.value = show_y_reg ? py_reg[sel_reg] : px_reg[sel_reg];
				disp_next.xmark = !show_y_reg;
			end
		endcase
	end

	// ==========================================================
	// Sequential logic.
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			k1_reg <= 3'h0; k2_reg <= 3'h0; k3_reg <= 3'h0;
			key_reg <= 3'h0; key_prev_reg <= 3'h0;
			ack_reg <= 1'b0; rdata_reg <= 32'h0000_0000;
			meas_reg <= '0; disp_reg <= '0;
		end
		else
		begin
			k1_reg <= keys_i;
			k2_reg <= k1_reg;
			k3_reg <= k2_reg;
			key_reg <= (k2_reg & k3_reg) | (key_reg & (k2_reg | k3_reg));
			key_prev_reg <= key_reg;
			ack_reg <= req;
			rdata_reg <= rd_mux;
			disp_reg <= disp_next;
			if (sample_valid_i)
			begin
				meas_reg.code  <= meas_code;
				meas_reg.value <= (meas_code == SHOW_VALUE) ? 16'(result) : 16'h0000;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			mode_reg <= MODE_4_20; char_reg <= CHAR_LIN; wire_reg <= WIRE_4; dec_reg <= 2'h0;
			offset_reg <= 16'h0000; dlo_reg <= RST_DISP_LO; dhi_reg <= RST_DISP_HI;
			lor_reg <= 10'h000; hir_reg <= 10'h000;
			stage_x_reg <= 16'h0000; stage_y_reg <= 16'h0000;
			count_reg <= 5'h00; sel_reg <= 5'h00; dup_reg <= 1'b0; show_y_reg <= 1'b0;
			long_done_reg <= 1'b0; remove_op_reg <= 1'b0; timer_reg <= 32'h0; ui_reg <= UI_IDLE;
			for (int i = 0; i < MAX_POINTS; i++)
			begin
				px_reg[i] <= 16'h0000;
				py_reg[i] <= 16'h0000;
			end
		end
		else
		begin
			ui_reg <= ui_next;
			timer_reg <= (ui_next != ui_reg || (ui_reg != UI_COUNT && !enter)) ? 32'h0
				: timer_reg + 32'h1;
			if (wr_full)
				case (avs_address_i)
					OFS_CTRL:
					begin
						mode_reg <= input_mode_t'(avs_writedata_i[CTRL_MODE_LSB +: 4]);
						char_reg <= char_t'(avs_writedata_i[CTRL_CHAR_LSB +: 2]);
						wire_reg <= wiring_t'(avs_writedata_i[CTRL_WIRE_LSB +: 2]);
						dec_reg  <= avs_writedata_i[CTRL_DEC_LSB +: 2];
					end
					OFS_OFFSET:  offset_reg <= 16'(clampi(int'($signed(wd_lo)), -OFS_TC_MAX,
						OFS_TC_MAX));
					OFS_DISP_LO: if (!is_user) dlo_reg <= 16'(clampi(int'($signed(wd_lo)),
						DISP_MIN, DISP_MAX));
					OFS_DISP_HI: if (!is_user) dhi_reg <= 16'(clampi(int'($signed(wd_lo)),
						DISP_MIN, DISP_MAX));
					OFS_RANGE_EXP:
					begin
						lor_reg <= 10'(clampi(int'(avs_writedata_i[RX_LO_LSB +: 10]), 0, LOR_MAX));
						hir_reg <= 10'(clampi(int'(avs_writedata_i[RX_HI_LSB +: 10]), 0, HIR_MAX));
					end
					OFS_PT_STAGE:
					begin
						stage_x_reg <= 16'(clampi(int'($signed(avs_writedata_i[PT_X_LSB +: 16])),
							X_MIN, X_MAX));
						stage_y_reg <= 16'(clampi(int'($signed(avs_writedata_i[PT_Y_LSB +: 16])),
							DISP_MIN, DISP_MAX));
					end
					default: ;
				endcase
			// A refused command shows its warning until the next command arrives.
			if (cmd_wr)
				dup_reg <= (app_req && !app_ok) || (cmt_req && !edit_ok);
			if (app_ok)
			begin
				px_reg[count_reg] <= stage_x_reg;
				py_reg[count_reg] <= stage_y_reg;
				count_reg <= count_reg + 5'h01;
			end
			if (edit_ok && show_y_reg)
				py_reg[sel_reg] <= stage_y_reg;
			if (edit_ok && !show_y_reg)
				px_reg[sel_reg] <= stage_x_reg;
			if (del_now && count_reg != 5'h00)
			begin
				for (int i = 0; i < MAX_POINTS - 1; i++)
					if (5'(i) >= sel_reg)
					begin
						px_reg[i] <= px_reg[i + 1];
						py_reg[i] <= py_reg[i + 1];
					end
				count_reg <= count_reg - 5'h01;
				sel_reg <= 5'h00;
			end
			if (ui_reg == UI_IDLE && ui_next == UI_COUNT)
			begin
				remove_op_reg <= (cmd == CMD_REMOVE);
				sel_reg <= 5'h00;
				show_y_reg <= 1'b0;
			end
			if (ui_reg == UI_IDLE && up_ev && dec_reg != 2'h3)
				dec_reg <= dec_reg + 2'h1;
			if (ui_reg == UI_IDLE && down_ev && dec_reg != 2'h0)
				dec_reg <= dec_reg - 2'h1;
			if (ui_reg == UI_SELECT && up_ev)
				sel_reg <= (sel_reg + 5'h01 >= count_reg) ? 5'h00 : sel_reg + 5'h01;
			if (ui_reg == UI_SELECT && down_ev)
				sel_reg <= (sel_reg == 5'h00) ? count_reg - 5'h01 : sel_reg - 5'h01;
			if (ui_reg == UI_SELECT && ent_fall && !long_done_reg)
				show_y_reg <= !show_y_reg;
			if (long_hit)
				long_done_reg <= 1'b1;
			else if (!enter)
				long_done_reg <= 1'b0;
		end
	end

	assign avs_waitrequest_o = req;
	assign avs_readdata_o    = rdata_reg;
	assign rtd_wiring_o      = wire_reg;
	assign disp_o            = disp_reg;

	// ==========================================================
	// Assertions.
	a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("Read not answered after one wait cycle.");
	a_points_max: assert property (@(posedge clk_i) disable iff (!rstn_i)
		count_reg <= 5'(MAX_POINTS)) else $error("Point count above twenty.");
	a_dup_refused: assert property (@(posedge clk_i) disable iff (!rstn_i)
		app_req && x_dup |=> $stable(count_reg) && dup_reg ##1 disp_o.code == SHOW_DUP)
		else $error("Duplicate X was stored or not flagged.");
	a_few_points: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sample_valid_i && few_pts |=> meas_reg.code == SHOW_FEWPT)
		else $error("Few-points warning missing.");
	a_xmark_shown: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ui_reg == UI_SELECT && !show_y_reg |=> disp_o.xmark)
		else $error("X shown without extra decimal point.");
	a_count_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(ui_reg == UI_COUNT) && is_user |-> (ui_reg == UI_COUNT)[*8])
		else $error("Point count left too early.");
	a_under_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sample_valid_i && below && !few_pts |=> meas_reg.code == SHOW_UNDER)
		else $error("Under-range warning missing.");
	a_ovfl_in_range: assert property (@(posedge clk_i) disable iff (!rstn_i)
		sample_valid_i && !below && !above && ovfl && !few_pts |=> meas_reg.code == SHOW_OVFL)
		else $error("Overflow warning missing.");
	a_hidden_ops: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_wr && !is_user |=> ui_reg == UI_IDLE) else $error("Point function while hidden.");

	c_append: cover property (@(posedge clk_i) disable iff (!rstn_i) app_ok);
	c_remove: cover property (@(posedge clk_i) disable iff (!rstn_i) del_now);
	c_commit: cover property (@(posedge clk_i) disable iff (!rstn_i) edit_ok);
	c_over:   cover property (@(posedge clk_i) disable iff (!rstn_i)
		sample_valid_i && above);

endmodule

// ==== verification/sensor_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Front end model
// The line is scrambled between strobes so that a stale value is never trusted.
module sensor_model (
	input  wire logic          clk_i,   // system clock
	output logic               valid_o, // one-cycle sample strobe
	output logic signed [23:0] value_o  // uA, mV or 0.1 C
);
	initial
	begin
		valid_o = 1'b0;
		value_o = 24'h000000;
	end
	task automatic send(input logic signed [23:0] v);
		@(posedge clk_i);
		valid_o <= 1'b1;
		value_o <= v;
		@(posedge clk_i);
		valid_o <= 1'b0;
		value_o <= ~v;
	endtask
endmodule

// ==== verification/input_scaling_range_check_bench.sv ====
`timescale 1ns/100ps
module input_scaling_range_check_bench import input_scaling_pkg::*;;
	logic               clk_i, rstn_i, avs_read_i, avs_write_i, sample_valid_i, avs_waitrequest_o;
	logic [5:0]         avs_address_i;
	logic [31:0]        avs_writedata_i, avs_readdata_o, rd;
	logic [3:0]         avs_byteenable_i;
	logic [2:0]         keys_i;
	logic signed [23:0] sample_i;
	logic [1:0]         w;
	wiring_t            rtd_wiring_o;
	display_t           disp_o;
	int                 fails, comparisons;

	// Short counts keep the long-press and count-display phases in reach.
	input_scaling_range_check #(.COUNT_SHOW(20), .LONG_PRESS(30)) dut (.clk_i(clk_i),
		.rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .sample_valid_i(sample_valid_i),
		.sample_i(sample_i), .keys_i(keys_i), .rtd_wiring_o(rtd_wiring_o), .disp_o(disp_o));
	sensor_model sm (.clk_i(clk_i), .valid_o(sample_valid_i), .value_o(sample_i));

	// ==========================================================
	// Shared tasks
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 50);
		rd = avs_readdata_o;
		if (avs_waitrequest_o !== 1'b0)
		begin
			fails++;
			final_report();
		end
		else
		begin
			avs_write_i <= 1'b0;
			avs_read_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task automatic measure(input logic signed [23:0] v, input show_t c, input logic [15:0] val);
		sm.send(v);
		repeat (5) @(posedge clk_i);
		chk({12'h000, disp_o.code, (c == SHOW_VALUE) ? disp_o.value : 16'h0000}, {12'h000, c, val});
	endtask
	task automatic key(input logic [2:0] k, input int hold);
		keys_i <= k;
		repeat (hold) @(posedge clk_i);
		keys_i <= 3'h0;
		repeat (10) @(posedge clk_i);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_wiring();
		bus(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h00000001);
		bus(1'b0, OFS_DISP_HI, 32'h0);
		chk(rd, 32'h000003E8);
		bus(1'b0, 6'h24, 32'h0);
		chk(rd, 32'h00000000);
		for (w = 2'h0; w < 2'h3; w++)
		begin
			bus(1'b1, OFS_CTRL, {22'h000000, w, 8'h01});
			chk({30'h0, rtd_wiring_o}, {30'h0, w});
		end
		bus(1'b1, OFS_COMMAND, 32'h2);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h001F0000, 32'h00010000);
		$display("done reset and wiring");
	endtask
	task automatic t_ranges();
		measure(24'h002EE0, SHOW_VALUE, 16'h01F4);
		measure(24'h000F9F, SHOW_UNDER, 16'h0000);
		measure(24'h004E21, SHOW_OVER, 16'h0000);
		bus(1'b1, OFS_RANGE_EXP, 32'h000001F4);
		measure(24'h0007D0, SHOW_VALUE, 16'hFF83);
		measure(24'h0007CF, SHOW_UNDER, 16'h0000);
		bus(1'b1, OFS_CTRL, 32'h00000000);
		measure(24'hFFFFFF, SHOW_UNDER, 16'h0000);
		measure(24'h004E20, SHOW_VALUE, 16'h03E8);
		bus(1'b1, OFS_CTRL, 32'h00000010);
		measure(24'h002710, SHOW_VALUE, 16'h00FA);
		bus(1'b1, OFS_CTRL, 32'h00000020);
		measure(24'h002710, SHOW_VALUE, 16'h02C3);
		bus(1'b1, OFS_CTRL, 32'h00000001);
		bus(1'b1, OFS_DISP_HI, 32'h0000270F);
		bus(1'b1, OFS_RANGE_EXP, 32'h00C70000);
		measure(24'h0055F0, SHOW_OVFL, 16'h0000);
		measure(24'h005DC0, SHOW_OVER, 16'h0000);
		bus(1'b1, OFS_OFFSET, 32'h000001F4);
		bus(1'b1, OFS_CTRL, 32'h00000006);
		measure(24'h0003E8, SHOW_VALUE, 16'h044B);
		bus(1'b1, OFS_CTRL, 32'h00000007);
		measure(24'h0003E8, SHOW_VALUE, 16'h05DC);
		$display("done ranges");
	endtask
	task automatic t_table();
		bus(1'b1, OFS_CTRL, 32'h00000031);
		measure(24'h002EE0, SHOW_FEWPT, 16'h0000);
		bus(1'b1, OFS_PT_STAGE, 32'h00640000);
		bus(1'b1, OFS_COMMAND, 32'h1);
		bus(1'b1, OFS_PT_STAGE, 32'h012C03E8);
		bus(1'b1, OFS_COMMAND, 32'h1);
		bus(1'b1, OFS_PT_STAGE, 32'h019003E8);
		bus(1'b1, OFS_COMMAND, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h3F, 32'h00000022);
		chk({28'h0, disp_o.code}, {28'h0, SHOW_DUP});
		bus(1'b1, OFS_COMMAND, 32'h0);
		measure(24'h002EE0, SHOW_VALUE, 16'h00C8);
		bus(1'b1, OFS_DISP_LO, 32'h00000005);
		bus(1'b0, OFS_DISP_LO, 32'h0);
		chk(rd, 32'h00000064);
		key(3'h4, 10);
		chk({30'h0, disp_o.decimals}, 32'h1);
		bus(1'b1, OFS_COMMAND, 32'h2);
		chk({12'h000, disp_o.code, disp_o.value}, {12'h000, SHOW_COUNT, 16'h0002});
		repeat (25) @(posedge clk_i);
		key(3'h1, 40);
		chk({28'h0, disp_o.code}, {28'h0, SHOW_PROMPT});
		key(3'h1, 10);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h1F, 32'h00000001);
		repeat (25) @(posedge clk_i);
		chk({31'h0, disp_o.xmark}, 32'h1);
		key(3'h1, 5);
		chk({31'h0, disp_o.xmark}, 32'h0);
		bus(1'b1, OFS_COMMAND, 32'h0);
		for (int i = 0; i < 20; i++)
		begin
			bus(1'b1, OFS_PT_STAGE, 32'(i * 10 + 5));
			bus(1'b1, OFS_COMMAND, 32'h1);
		end
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd & 32'h3F, 32'h00000034);
		$display("done table");
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		rstn_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 6'h00;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hF;
		keys_i = 3'h0;
		fails = 0;
		comparisons = 0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		t_reset_wiring();
		t_ranges();
		t_table();
		final_report();
	end
endmodule
